// ==== rtl/cspt_ctrl.sv ====
// Operation
// [RULE1] status bit 0: 0 supervisor, 1 user; resets to supervisor
// [RULE2] status bit 1 gates external interrupts; resets to zero
// [RULE3] status bit 2 turns address translation on; resets to zero
// [RULE4] status bit 3: speculative loads and purges raise no-mapping faults
// [RULE5] status bit 4: misaligned speculative loads raise an exception
// [RULE6] bits 8 and 9 enable data and instruction watches; reset zero
// [RULE7] bit 12 marks debug mode; resets to zero
// [RULE8] set and clear operations change all masked bits at once
// [RULE9] trap return loads stashed status and counter together
// [RULE10] software stashes new status and resume address before return
// [RULE11] software keeps interrupts off through the update sequence
// [RULE12] no interlock from stash stores to trap return; software spaces
// [RULE13] three stages; operands read in stage one, results end stage three
// [RULE14] add/subtract latency one cycle; multiply/load latency three
// [RULE15] untaken branch free; taken branch stalls one cycle, more on cross
// [RULE16] stall dependent operations reading results too early
// [RULE17] return, set, clear and purges drain the pipeline first
// [RULE18] early link copy updated at issue feeds indirect branches
// [RULE19] trap handlers rewrite the link register before using it
// [RULE20] stall indirect branch if link written in previous three bundles; code counts three cycles after the link write, stalls included
// [RULE21] on trap, older bundles finish, trapping and later discarded
// [RULE22] trap point is the faulting or interrupted bundle
// [RULE23] traps in program order; interrupt is external-interrupt cause
// [RULE24] trap entry stashes status and pc, clears user, int, watches
// [RULE25] only the highest priority exception reaches the handler
// [RULE26] reserved status bits read zero and ignore writes
//
// Purpose: status word, interlocks, drains and precise trap entry
// Assumes: issue holds the bundle while STALL_O is high
// Notes:   the external interrupt pin is synchronised before use
`timescale 1ns/1ps
module cspt_ctrl (
    // clock and reset
    input  wire logic                  SYS_CLK_I,
    input  wire logic                  RESET_I,
    // register port
    input  wire logic [3:0]            REG_ADDR_I,
    input  wire logic [31:0]           REG_WDATA_I,
    input  wire logic                  REG_WR_I,
    input  wire logic                  REG_RD_I,
    output logic      [31:0]           REG_RDATA_O,
    // issued bundle
    input  wire cspt_pkg::cspt_bundle_s BUNDLE_I,
    input  wire logic                  EXT_IRQ_I,
    // pipeline control
    output logic                       STALL_O,
    output logic                       REDIRECT_O,
    output logic      [31:0]           REDIRECT_PC_O,
    output logic                       FLUSH_O,
    output logic      [31:0]           STATUS_O,
    output logic      [31:0]           LINK_COPY_O,
    output logic      [4:0]            CAUSE_O
);

    logic [31:0] status;
    logic [31:0] stash_sw;
    logic [31:0] stash_pc;
    logic [31:0] nstash_sw;
    logic [31:0] nstash_pc;
    logic [31:0] vector;
    logic [4:0]  cause;
    logic [31:0] link_copy;
    logic        irq_meta;
    logic        irq_sync;
    logic        br_bubble;
    logic [1:0]  link_age;
    logic        stall_q;
    logic        redirect;
    logic [31:0] redirect_pc;
    logic        flush;
    logic [31:0] rdata;
    cspt_pkg::cspt_state_e state;
    cspt_pkg::cspt_stage_s stg [cspt_pkg::PIPE_DEPTH];

    // decode of the issued bundle
    wire cspt_pkg::cspt_bundle_s b = BUNDLE_I;
    wire is_drain_op = b.sw_set | b.sw_clr | b.trap_ret | b.purge;
    wire irq_take    = irq_sync & status[cspt_pkg::BIT_INT_EN]; // [RULE2]
    wire [14:0] exc_all = {b.exc[14:3], b.exc[2] | irq_take, b.exc[1:0]};
    wire exc_any = b.valid & (|exc_all);

    // hazard detection over the three stages
    logic [cspt_pkg::PIPE_DEPTH-1:0] raw_hit;
    logic [cspt_pkg::PIPE_DEPTH-1:0] busy;
    genvar gi;
    generate
        for (gi = 0; gi < cspt_pkg::PIPE_DEPTH; gi++) begin : g_haz
            // operand needed before producer has a bypassable result
            assign raw_hit[gi] = stg[gi].valid & stg[gi].dst_we
                & (stg[gi].dst != 6'h00) & (stg[gi].ready_in != 2'h0)
                & ((stg[gi].dst == b.src_a) | (stg[gi].dst == b.src_b));
            assign busy[gi] = stg[gi].valid;
        end
    endgenerate

    wire raw_stall   = b.valid & (|raw_hit);                  // [RULE16]
    wire drain_stall = b.valid & is_drain_op & (|busy);       // [RULE17]
    wire link_stall  = b.valid & b.ind_br
                     & (link_age != 2'h0);                    // [RULE20]
    // stash stores feed trap return with no interlock, by design [RULE12]
    wire hold = ~exc_any & (raw_stall | drain_stall | link_stall | br_bubble);
    wire issue = b.valid & ~hold & ~exc_any;

    // highest priority cause: lowest index wins
    logic [4:0] next_cause;
    always_comb begin
        next_cause = 5'h00;
        for (int i = 14; i >= 0; i--) begin
            if (exc_all[i]) begin
                next_cause = 5'(i);                           // [RULE25]
            end
        end
    end

    // interrupt pin synchroniser
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            irq_meta <= 1'b0;
            irq_sync <= 1'b0;
        end else begin
            irq_meta <= EXT_IRQ_I;
            irq_sync <= irq_meta;
        end
    end

    // stage one takes issued bundles, results leave at stage three [RULE13]
    cspt_pkg::cspt_stage_s next_s0;
    always_comb begin
        next_s0          = '0;
        next_s0.valid    = issue;
        next_s0.dst_we   = b.dst_we;
        next_s0.dst      = b.dst;
        next_s0.drain    = is_drain_op;
        // latency minus one cycles before a result may be bypassed [RULE14]
        next_s0.ready_in = b.long_lat ? cspt_pkg::LAT_LONG - 2'h1
                                      : cspt_pkg::LAT_SIMPLE - 2'h1;
    end

    // stage shift; a trap discards only the trapping bundle, older finish
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            for (int i = 0; i < cspt_pkg::PIPE_DEPTH; i++) begin
                stg[i] <= '0;
            end
        end else begin
            stg[0] <= next_s0;                                // [RULE21]
            for (int i = 1; i < cspt_pkg::PIPE_DEPTH; i++) begin
                stg[i]          <= stg[i-1];
                stg[i].ready_in <= (stg[i-1].ready_in == 2'h0) ? 2'h0
                                   : stg[i-1].ready_in - 2'h1;
            end
        end
    end

    // taken-branch bubble and link write age
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            br_bubble <= 1'b0;
            link_age  <= 2'h0;
            link_copy <= 32'h0000_0000;
        end else begin
            // one cycle, plus one when the target crosses a line [RULE15]
            br_bubble <= issue & b.taken_br & ~br_bubble
                       | (br_bubble & b.line_cross & ~stall_q);
            if (issue & b.link_wr) begin
                link_age  <= cspt_pkg::LINK_WIN;              // [RULE20]
                link_copy <= b.link_val;                      // [RULE18]
            end else if (link_age != 2'h0) begin
                link_age  <= link_age - 2'h1;
            end
        end
    end

    // register port write decode
    wire wr_status = REG_WR_I & (REG_ADDR_I == cspt_pkg::ADDR_STATUS);
    wire wr_ssw    = REG_WR_I & (REG_ADDR_I == cspt_pkg::ADDR_STASH_SW);
    wire wr_spc    = REG_WR_I & (REG_ADDR_I == cspt_pkg::ADDR_STASH_PC);
    wire wr_nsw    = REG_WR_I & (REG_ADDR_I == cspt_pkg::ADDR_NSTASH_SW);
    wire wr_npc    = REG_WR_I & (REG_ADDR_I == cspt_pkg::ADDR_NSTASH_PC);
    wire wr_vec    = REG_WR_I & (REG_ADDR_I == cspt_pkg::ADDR_VECTOR);
    wire wr_cause  = REG_WR_I & (REG_ADDR_I == cspt_pkg::ADDR_CAUSE);

    // next status: trap, then return, set, clear, then software write
    wire [31:0] wm = cspt_pkg::STATUS_WMASK;
    wire [31:0] next_status =
        exc_any ? (status & ~cspt_pkg::TRAP_CLR)              // [RULE24]
      : (issue & b.trap_ret) ? (stash_sw & wm)                // [RULE9]
      : (issue & b.sw_set) ? ((status | b.mask) & wm)         // [RULE8]
      : (issue & b.sw_clr) ? (status & ~b.mask & wm)          // [RULE8]
      : wr_status ? (REG_WDATA_I & wm)                        // [RULE26]
      : status;

    // status word and stash registers
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            status    <= cspt_pkg::STATUS_RESET;     // [RULE1] [RULE3] [RULE7]
            stash_sw  <= 32'h0000_0000;
            stash_pc  <= 32'h0000_0000;
            nstash_sw <= 32'h0000_0000;
            nstash_pc <= 32'h0000_0000;
            vector    <= cspt_pkg::VECTOR_RESET;
            cause     <= 5'h00;
        end else begin
            status <= next_status;
            if (exc_any) begin
                stash_sw <= status;                           // [RULE24]
                stash_pc <= b.pc;                             // [RULE22]
                cause    <= next_cause;                       // [RULE23]
            end else begin
                if (wr_ssw) stash_sw <= REG_WDATA_I & wm;
                if (wr_spc) stash_pc <= REG_WDATA_I;
                if (wr_cause) cause <= REG_WDATA_I[4:0];
            end
            if (wr_nsw) nstash_sw <= REG_WDATA_I & wm;
            if (wr_npc) nstash_pc <= REG_WDATA_I;
            if (wr_vec) vector <= REG_WDATA_I;
        end
    end

    // control state and redirect
    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            state       <= cspt_pkg::ST_RUN;
            redirect    <= 1'b0;
            redirect_pc <= 32'h0000_0000;
            flush       <= 1'b0;
            stall_q     <= 1'b0;
        end else begin
            stall_q  <= hold;
            redirect <= exc_any | (issue & b.trap_ret);
            flush    <= exc_any;                              // [RULE21]
            if (exc_any) begin
                redirect_pc <= vector;                        // [RULE21]
            end else if (issue & b.trap_ret) begin
                redirect_pc <= stash_pc;                      // [RULE9]
            end
            case (state)
                cspt_pkg::ST_RUN: begin
                    if (exc_any) state <= cspt_pkg::ST_TRAP;
                    else if (drain_stall) state <= cspt_pkg::ST_DRAIN;
                    else if (hold) state <= cspt_pkg::ST_STALL;
                end
                cspt_pkg::ST_STALL, cspt_pkg::ST_DRAIN: begin
                    if (exc_any) state <= cspt_pkg::ST_TRAP;
                    else if (!hold) state <= cspt_pkg::ST_RUN;
                end
                cspt_pkg::ST_TRAP: state <= cspt_pkg::ST_RUN;
                default: state <= cspt_pkg::ST_RUN;
            endcase
        end
    end

    // read data, one cycle after the read strobe
    logic [31:0] next_rdata;
    always_comb begin
        case (REG_ADDR_I)
            cspt_pkg::ADDR_STATUS:    next_rdata = status;
            cspt_pkg::ADDR_STASH_SW:  next_rdata = stash_sw;
            cspt_pkg::ADDR_STASH_PC:  next_rdata = stash_pc;
            cspt_pkg::ADDR_NSTASH_SW: next_rdata = nstash_sw;
            cspt_pkg::ADDR_NSTASH_PC: next_rdata = nstash_pc;
            cspt_pkg::ADDR_VECTOR:    next_rdata = vector;
            cspt_pkg::ADDR_CAUSE:     next_rdata = {27'h0, cause};
            cspt_pkg::ADDR_PIPE_STAT: next_rdata = {28'h0, state};
            default:                  next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RESET_I) begin
        if (RESET_I) rdata <= 32'h0000_0000;
        else rdata <= REG_RD_I ? next_rdata : 32'h0000_0000;
    end

    // outputs straight from flip-flops
    assign REG_RDATA_O   = rdata;
    assign STALL_O       = stall_q;
    assign REDIRECT_O    = redirect;
    assign REDIRECT_PC_O = redirect_pc;
    assign FLUSH_O       = flush;
    assign STATUS_O      = status;   // [RULE4] [RULE5] [RULE6] fields
    assign LINK_COPY_O   = link_copy;
    assign CAUSE_O       = cause;

    // checks
    chk_reserved_zero: assert property (@(posedge SYS_CLK_I) // [RULE26]
        disable iff (RESET_I) (status & ~cspt_pkg::STATUS_WMASK) == 32'h0)
        else $error("reserved status bits set");
    chk_trap_clears: assert property (@(posedge SYS_CLK_I) // [RULE24]
        disable iff (RESET_I) exc_any |=> (status[0] == 1'b0)
        && (status[1] == 1'b0) && (status[9:8] == 2'b00))
        else $error("trap entry did not clear bits");
    chk_trap_vector: assert property (@(posedge SYS_CLK_I) // [RULE21]
        disable iff (RESET_I) exc_any |=> redirect
        && redirect_pc == $past(vector))
        else $error("trap did not go to vector");
    chk_stash_pc: assert property (@(posedge SYS_CLK_I) // [RULE22]
        disable iff (RESET_I) exc_any |=> stash_pc == $past(b.pc))
        else $error("trap point not stashed");
    chk_ret_atomic: assert property (@(posedge SYS_CLK_I) // [RULE9]
        disable iff (RESET_I) (issue && b.trap_ret) |=>
        status == ($past(stash_sw) & wm) && redirect_pc == $past(stash_pc))
        else $error("trap return not atomic");
    chk_set_mask: assert property (@(posedge SYS_CLK_I) // [RULE8]
        disable iff (RESET_I) (issue && b.sw_set && !b.trap_ret) |=>
        ((status & $past(b.mask) & wm) == ($past(b.mask) & wm)))
        else $error("set missed a bit");
    chk_drain_empty: assert property (@(posedge SYS_CLK_I) // [RULE17]
        disable iff (RESET_I) (issue && is_drain_op) |-> busy == 3'b000)
        else $error("drain op issued into busy pipe");
    chk_link_window: assert property (@(posedge SYS_CLK_I) // [RULE20]
        disable iff (RESET_I) (issue && b.link_wr) |=>
        !(issue && b.ind_br) [*3])
        else $error("indirect branch inside link window");
    chk_raw_stall: assert property (@(posedge SYS_CLK_I) // [RULE16]
        disable iff (RESET_I) raw_stall && !exc_any |=> stall_q)
        else $error("hazard without stall");
    chk_branch_bubble: assert property (@(posedge SYS_CLK_I) // [RULE15]
        disable iff (RESET_I) (issue && b.taken_br && !br_bubble) |=>
        br_bubble ##1 stall_q)
        else $error("taken branch without bubble");
    chk_irq_masked: assert property (@(posedge SYS_CLK_I) // [RULE2]
        disable iff (RESET_I) (b.valid && b.exc == 15'h0000
        && !status[cspt_pkg::BIT_INT_EN]) |=> !flush)
        else $error("masked interrupt taken");
    chk_irq_cause: assert property (@(posedge SYS_CLK_I) // [RULE23]
        disable iff (RESET_I) (b.valid && irq_take && b.exc[1:0] == 2'b00)
        |=> flush && cause == cspt_pkg::CAUSE_EXT)
        else $error("interrupt not taken as its cause");
    chk_clr_mask: assert property (@(posedge SYS_CLK_I) // [RULE8]
        disable iff (RESET_I) (issue && b.sw_clr && !b.sw_set
        && !b.trap_ret) |=> (status & $past(b.mask)) == 32'h0)
        else $error("clear missed a bit");
    chk_link_copy: assert property (@(posedge SYS_CLK_I) // [RULE18]
        disable iff (RESET_I) (issue && b.link_wr) |=>
        link_copy == $past(b.link_val))
        else $error("early link copy not updated");
    chk_trap_discard: assert property (@(posedge SYS_CLK_I) // [RULE21]
        disable iff (RESET_I) exc_any |=> !stg[0].valid)
        else $error("trapping bundle entered the pipe");

endmodule

// ==== rtl/cspt_pkg.sv ====
// Purpose: shared constants and carriers for the status/pipeline/trap control
// Assumes: 32-bit status word, three execution stages, one core clock
// Notes:   register offsets are word offsets on the plain register port
package cspt_pkg;

    // register port offsets
    localparam logic [3:0] ADDR_STATUS     = 4'h0;
    localparam logic [3:0] ADDR_STASH_SW   = 4'h1;
    localparam logic [3:0] ADDR_STASH_PC   = 4'h2;
    localparam logic [3:0] ADDR_NSTASH_SW  = 4'h3;
    localparam logic [3:0] ADDR_NSTASH_PC  = 4'h4;
    localparam logic [3:0] ADDR_VECTOR     = 4'h5;
    localparam logic [3:0] ADDR_CAUSE      = 4'h6;
    localparam logic [3:0] ADDR_PIPE_STAT  = 4'h7;

    // status word field positions
    localparam int BIT_USER     = 0;
    localparam int BIT_INT_EN   = 1;
    localparam int BIT_XLATE    = 2;
    localparam int BIT_NOMAP    = 3;
    localparam int BIT_MISALIGN = 4;
    localparam int BIT_DWATCH   = 8;
    localparam int BIT_IWATCH   = 9;
    localparam int BIT_DEBUG    = 12;

    // writable bits of the status word; the rest read as zero
    localparam logic [31:0] STATUS_WMASK = 32'h0000_131F;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    // bits dropped on trap entry: user, interrupt enable, both watches
    localparam logic [31:0] TRAP_CLR     = 32'h0000_0303;
    localparam logic [31:0] VECTOR_RESET = 32'h0000_0000;

    // latencies in cycles
    localparam logic [1:0] LAT_SIMPLE = 2'h1;
    localparam logic [1:0] LAT_LONG   = 2'h3;
    localparam int         PIPE_DEPTH = 3;
    localparam logic [1:0] LINK_WIN   = 2'h3;
    localparam logic [5:0] LINK_REG   = 6'h3F;
    localparam logic [4:0] CAUSE_EXT  = 5'h02;

    // issued bundle as seen by the control block
    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic [5:0]  src_a;
        logic [5:0]  src_b;
        logic [5:0]  dst;
        logic        dst_we;
        logic        long_lat;  // multiply or load
        logic        taken_br;
        logic        line_cross;
        logic        ind_br;    // register-indirect call or jump
        logic        link_wr;   // writes the link register
        logic [31:0] link_val;
        logic        sw_set;
        logic        sw_clr;
        logic        trap_ret;
        logic        purge;     // instruction-cache purge or page purge
        logic [31:0] mask;
        logic [14:0] exc;       // one bit per raised exception cause
    } cspt_bundle_s;

    // pipeline stage entry for latency tracking
    typedef struct packed {
        logic       valid;
        logic       dst_we;
        logic [5:0] dst;
        logic [1:0] ready_in;  // cycles until result may be bypassed
        logic       drain;
    } cspt_stage_s;

    typedef enum logic [3:0] {
        ST_RUN   = 4'h1,
        ST_STALL = 4'h2,
        ST_DRAIN = 4'h4,
        ST_TRAP  = 4'h8
    } cspt_state_e;

endpackage

// ==== sim/cspt_issue_model.sv ====
// Purpose: issue-stage model that feeds bundles to the control block
// Assumes: a held bundle shows as a stall flag just after the edge
// Notes:   a flush drops the presented bundle; each wait is bounded
`timescale 1ns/1ps
module cspt_issue_model (
    // clock
    input  wire logic              clk_i,
    // feedback from the control block
    input  wire logic              stall_i,
    input  wire logic              flush_i,
    // bundle toward the control block
    output cspt_pkg::cspt_bundle_s bundle_o
);
    // empty slot until a bundle is issued
    initial bundle_o = '0;

    // present, hold while stalled, then empty the slot unless more follow
    task automatic issue(input  cspt_pkg::cspt_bundle_s b,
                         input  logic                   more,
                         output int                     held,
                         output logic                   trapped);
        held     = -1;
        trapped  = 1'b0;
        bundle_o = b;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk_i);
            #1;
            if (flush_i === 1'b1) begin
                trapped = 1'b1;
                held    = n;
                break;
            end
            if (stall_i !== 1'b1) begin
                held = n;
                break;
            end
        end
        if (!more) bundle_o = '0;
    endtask
endmodule

// ==== sim/tb_core_status_pipeline_trap_ctrl.sv ====
// Purpose: self-checking bench for the status, pipeline and trap control
// Assumes: the issue model holds each bundle while the block stalls
// Notes:   random values come from one fixed seed
`timescale 1ns/1ps
module tb_core_status_pipeline_trap_ctrl;
    logic                   SYS_CLK_I;
    logic                   RESET_I;
    logic [3:0]             REG_ADDR_I;
    logic [31:0]            REG_WDATA_I;
    logic                   REG_WR_I;
    logic                   REG_RD_I;
    logic [31:0]            REG_RDATA_O;
    cspt_pkg::cspt_bundle_s BUNDLE_I;
    logic                   EXT_IRQ_I;
    logic                   STALL_O;
    logic                   REDIRECT_O;
    logic [31:0]            REDIRECT_PC_O;
    logic                   FLUSH_O;
    logic [31:0]            STATUS_O;
    logic [31:0]            LINK_COPY_O;
    logic [4:0]             CAUSE_O;
    int                     n_errors;
    int                     num_checks;
    int                     held;
    logic                   trp;
    logic [31:0]            r, s, v, m;
    cspt_pkg::cspt_bundle_s b, c;

    // device and issue-side partner
    cspt_ctrl cspt_ctrl_inst (
        .SYS_CLK_I(SYS_CLK_I), .RESET_I(RESET_I), .REG_ADDR_I(REG_ADDR_I),
        .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I),
        .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
        .BUNDLE_I(BUNDLE_I), .EXT_IRQ_I(EXT_IRQ_I), .STALL_O(STALL_O),
        .REDIRECT_O(REDIRECT_O), .REDIRECT_PC_O(REDIRECT_PC_O),
        .FLUSH_O(FLUSH_O), .STATUS_O(STATUS_O),
        .LINK_COPY_O(LINK_COPY_O), .CAUSE_O(CAUSE_O));
    cspt_issue_model cspt_issue_model_inst (
        .clk_i(SYS_CLK_I), .stall_i(STALL_O), .flush_i(FLUSH_O),
        .bundle_o(BUNDLE_I));

    // 20 MHz core clock
    always #25 SYS_CLK_I = ~SYS_CLK_I;

    // writable status bits: low five controls, both watches, debug
    function automatic logic [31:0] wm();
        return 32'h0000001F | 32'h00000300 | 32'h00001000;
    endfunction
    // lowest set cause index wins
    function automatic logic [4:0] low_cause(input logic [14:0] e);
        low_cause = 5'h00;
        for (int i = 14; i >= 0; i--) if (e[i]) low_cause = 5'(i);
    endfunction
    // plain valid bundle with fixed registers
    function automatic cspt_pkg::cspt_bundle_s mk();
        mk       = '0;
        mk.valid = 1'b1;
        mk.pc    = $urandom() & 32'hFFFFFFFC;
        mk.src_a = 6'h01;
        mk.src_b = 6'h02;
        mk.dst   = 6'h05;
    endfunction

    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] want,
                       input string msg);
        num_checks++;
        if (got !== want) begin
            n_errors++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg,
                     got, want);
        end
    endtask
    // register port cycles; each ends just after an edge
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge SYS_CLK_I);
        REG_ADDR_I  <= a;
        REG_WDATA_I <= d;
        REG_WR_I    <= 1'b1;
        @(posedge SYS_CLK_I);
        REG_WR_I    <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge SYS_CLK_I);
        REG_ADDR_I <= a;
        REG_RD_I   <= 1'b1;
        @(posedge SYS_CLK_I);
        REG_RD_I   <= 1'b0;
        #1;
        d = REG_RDATA_O;
    endtask
    task automatic iss(input cspt_pkg::cspt_bundle_s x,
                       input logic more = 1'b0);
        cspt_issue_model_inst.issue(x, more, held, trp);
        if (held < 0) begin
            n_errors++;
            $display("mismatch at %0t: issue wait ran out", $time);
            complete_run();
        end
    endtask
    task automatic idle();
        repeat (5) @(posedge SYS_CLK_I);
        #1;
    endtask
    task automatic pair(input cspt_pkg::cspt_bundle_s x,
                        input cspt_pkg::cspt_bundle_s y,
                        input int want, input string msg);
        idle();
        iss(x, 1'b1);
        iss(y);
        cmp(32'(held), 32'(want), msg);
    endtask

    // hang guard
    initial begin
        repeat (100000) @(posedge SYS_CLK_I);
        n_errors++;
        complete_run();
    end

    // main sequence
    initial begin
        SYS_CLK_I = 1'b0; RESET_I = 1'b1; REG_ADDR_I = 4'h0;
        REG_WDATA_I = 32'h0; REG_WR_I = 1'b0; REG_RD_I = 1'b0;
        EXT_IRQ_I = 1'b0; n_errors = 0; num_checks = 0;
        void'($urandom(32'h7484D51E));
        repeat (20) @(posedge SYS_CLK_I);
        RESET_I <= 1'b0;
        cmp(STATUS_O, 32'h0, "status reset");
        rd(cspt_pkg::ADDR_STATUS, r);
        cmp(r, 32'h0, "status read reset");
        for (int i = 0; i < 6; i++) begin
            s = $urandom() & ~32'h2;
            wr(cspt_pkg::ADDR_STATUS, s);
            rd(cspt_pkg::ADDR_STATUS, r);
            cmp(r, s & wm(), "status rw");
            rd(4'h8 | 4'($urandom() & 7), r);
            cmp(r, 32'h0, "unmapped read");
        end
        // set, clear and purge each wait for an empty pipeline
        wr(cspt_pkg::ADDR_STATUS, 32'h0);
        s = 32'h0;
        for (int i = 0; i < 9; i++) begin
            b = mk();
            b.mask = $urandom() & ~32'h2;
            b.sw_set = (i % 3 == 0);
            b.sw_clr = (i % 3 == 1);
            b.purge = (i % 3 == 2);
            iss(b, i < 8);
            if (b.sw_set) s = s | (b.mask & wm());
            if (b.sw_clr) s = s & ~b.mask;
            cmp(STATUS_O, s, "set clear");
            if (i > 0) cmp(32'(held >= 1 && held <= 3), 32'h1, "drain");
        end
        // latency and branch interlocks
        b = mk(); b.dst_we = 1'b1;
        c = mk(); c.src_b = 6'h05;
        pair(b, c, 0, "simple dep");
        b.long_lat = 1'b1;
        pair(b, c, 2, "long dep");
        pair(b, mk(), 0, "long indep");
        b = mk(); b.taken_br = 1'b1;
        pair(b, mk(), 1, "taken branch");
        c = mk(); c.line_cross = 1'b1;
        pair(b, c, 2, "line cross");
        pair(mk(), mk(), 0, "not taken");
        // early link copy and indirect branch interlock
        idle();
        b = mk(); b.link_wr = 1'b1; b.link_val = $urandom();
        iss(b, 1'b1);
        cmp(LINK_COPY_O, b.link_val, "link copy");
        c = mk(); c.ind_br = 1'b1;
        iss(c, 1'b1);
        cmp(32'(held > 0), 32'h1, "link interlock");
        iss(b, 1'b1);
        repeat (3) iss(mk(), 1'b1);
        iss(c);
        cmp(32'(held), 32'h0, "link settled");
        // precise trap entry, then handler return
        for (int i = 0; i < 4; i++) begin
            v = $urandom() & 32'hFFFFFFFC;
            s = $urandom() & wm() & ~32'h2;
            wr(cspt_pkg::ADDR_VECTOR, v);
            wr(cspt_pkg::ADDR_STATUS, s);
            idle();
            b = mk();
            b.exc = 15'($urandom()) | (15'h1 << (i * 4));
            iss(b);
            cmp(32'(trp), 32'h1, "trap taken");
            cmp(32'(REDIRECT_O), 32'h1, "trap redirect");
            cmp(REDIRECT_PC_O, v, "vector");
            cmp(32'(CAUSE_O), 32'(low_cause(b.exc)), "cause");
            cmp(STATUS_O, s & ~32'h303, "trap status");
            rd(cspt_pkg::ADDR_STASH_SW, r);
            cmp(r, s, "stash status");
            rd(cspt_pkg::ADDR_STASH_PC, r);
            cmp(r, b.pc, "stash pc");
            c = mk(); c.link_wr = 1'b1; c.link_val = $urandom();
            iss(c);
            r = $urandom() & ~32'h2;
            m = $urandom() & 32'hFFFFFFFC;
            wr(cspt_pkg::ADDR_STASH_SW, r);
            wr(cspt_pkg::ADDR_STASH_PC, m);
            idle();
            b = mk(); b.trap_ret = 1'b1;
            iss(b);
            cmp(STATUS_O, r & wm(), "return status");
            cmp(REDIRECT_PC_O, m, "return pc");
            cmp(32'(REDIRECT_O), 32'h1, "return redirect");
        end
        // external interrupt, enabled then masked
        wr(cspt_pkg::ADDR_STATUS, 32'h2);
        EXT_IRQ_I <= 1'b1;
        idle();
        iss(mk());
        cmp(32'(trp), 32'h1, "irq taken");
        cmp(32'(CAUSE_O), 32'h2, "irq cause");
        cmp(STATUS_O, 32'h0, "irq status");
        idle();
        iss(mk());
        cmp(32'(trp), 32'h0, "irq masked");
        EXT_IRQ_I <= 1'b0;
        complete_run();
    end
endmodule
